/* File: vendor_cfg_consts.vh */
// Purpose: Constants for the vendor configuration extension registers
// Assumes: Config-space dword accesses with byte enables, one clock
// Notes: Offsets are byte addresses in the first controller's space
// Behaviour
// RULE1: Any state but fully on is global suspend with the clock stopped.
// RULE2: Port count resets to 5h; only 5h, 4h, 3h and 2h are legal.
// RULE3: Legacy select zero captures ports 60h/64h directly, no I/O window.
// RULE4: Legacy select one captures 60h/64h through the I/O base window.
// RULE5: Legacy enable pin low makes the legacy select bit ignored.
// RULE6: Software keeps tuning bits 4, 5, 6, 22 and second bit 6 zero.
// RULE7: Tuning fields reset to 3h, 3h, 10h, 6Ch and keep those values.
// RULE8: Identifier unlock resets zero; zero masks subsystem ID writes.
// RULE9: Bit 21, reset one, drives the port power control capability bit.
// RULE10: Always-on power: software clears capability, sets no-switching.
// RULE11: First-register fields but the unlock may preload from serial ROM.
// RULE12: First extension register sits at configuration offset E0h.
// RULE13: Clock select resets zero; zero picks 30-MHz crystal, one 48-MHz.
// RULE14: Second register bits 4:1 reset to 0h and stay zero. Here the write mask 7Eh lets writes set them.
// RULE15: Power state 00b fully on, 01b and 10b intermediate, 11b deepest.
// RULE16: Reserved bits read zero and ignore writes; bit 23 reads one.
`ifndef VENDOR_CFG_CONSTS_VH
`define VENDOR_CFG_CONSTS_VH
`define OFF_EXT_A      8'he0
`define OFF_EXT_B      8'he4
`define OFF_PMCSR      8'h84
`define OFF_SUBSYS     8'h2c
`define EXT_A_RESET    32'h6c30_3305
`define EXT_A_WMASK    32'hff7f_ffff
`define EXT_A_RO_ONE   32'h0080_0000
`define EXT_B_RESET    32'h0000_0000
`define EXT_B_WMASK    32'h0000_007e
`define PMCSR_WMASK    32'h0000_0003
`define SUBSYS_RESET   32'h0000_0000
`define PS_D0          2'h0
`define PS_D3          2'h3
`define BIT_PORT_LO    0
`define BIT_LEGC       3
`define BIT_UNLOCK     7
`define BIT_PPC        21
`define BIT_CLK_SEL    5
`define PORTS_MAX      3'h5
`define PORTS_MIN      3'h2
`define PORTS_W        3
`define UNLOCK_MASK    32'h0000_0080
`define PORT_EN_RESET  5'h1f
`define PORT_EN_ALL    5'h1f
`define PORT_EN_NONE   5'h00
`define PPC_RESET      1'b1
`define RDATA_RESET    32'h0000_0000
`endif

/* File: usb_host_vendor_config_regs.v */
// Purpose: Vendor configuration extension registers and derived controls
// Assumes: Synchronous single-cycle config reads and writes
// Notes: Serial ROM preload is taken before config access starts
`timescale 1ns/1ps
`default_nettype none
`include "vendor_cfg_consts.vh"
module usb_host_vendor_config_regs (
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        cfg_wr_in,
	input  wire        cfg_rd_in,
	input  wire [7:0]  cfg_addr_in,
	input  wire [3:0]  cfg_be_in,
	input  wire [31:0] cfg_wdata_in,
	input  wire        rom_load_in,
	input  wire [31:0] rom_data_in,
	input  wire        legacy_pin_in,
	output reg  [31:0] cfg_rdata_out,
	output reg         cfg_ack_out,
	output reg  [4:0]  port_enable_out,
	output reg         legacy_direct_out,
	output reg         legacy_window_out,
	output reg         port_power_control_cap_out,
	output reg         clk_sel_48m_out,
	output reg         suspend_out,
	output reg         clock_stop_out,
	output reg  [1:0]  power_state_out
);
	reg  [31:0] vendor_config_ext_a;
	reg  [31:0] vendor_config_ext_b;
	reg  [31:0] subsys_id;
	reg  [1:0]  power_state;
	reg         cfg_started;
	reg  [31:0] bmask;
	reg  [31:0] rdata;
	reg  [31:0] next_ext_a;
	reg  [31:0] next_ext_b;
	reg  [31:0] next_subsys;
	reg  [1:0]  next_power_state;
	reg  [31:0] rom_ext_a;
	reg  [2:0]  ports;
	reg         ports_legal;
	wire        cfg_access;
	wire        wr_ext_a;
	wire        wr_ext_b;
	wire        wr_pmcsr;
	wire        wr_subsys;
	wire        rom_take;

	assign cfg_access = cfg_wr_in | cfg_rd_in;
	assign wr_ext_a   = cfg_wr_in & (cfg_addr_in == `OFF_EXT_A); // RULE12
	assign wr_ext_b   = cfg_wr_in & (cfg_addr_in == `OFF_EXT_B);
	assign wr_pmcsr   = cfg_wr_in & (cfg_addr_in == `OFF_PMCSR);
	assign wr_subsys  = cfg_wr_in & (cfg_addr_in == `OFF_SUBSYS);
	// A config write in the same cycle beats the preload
	assign rom_take   = rom_load_in & ~cfg_started & ~cfg_wr_in; // RULE11

	always @* begin
		bmask = {{8{cfg_be_in[3]}}, {8{cfg_be_in[2]}},
			{8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}};
	end

	// Read-only and reserved bits never take write data
	always @* begin
		next_ext_a = (vendor_config_ext_a & ~(bmask & `EXT_A_WMASK)) |
			(cfg_wdata_in & bmask & `EXT_A_WMASK); // RULE16
		next_ext_b = (vendor_config_ext_b & ~(bmask & `EXT_B_WMASK)) |
			(cfg_wdata_in & bmask & `EXT_B_WMASK); // RULE16
		next_subsys = (subsys_id & ~bmask) | (cfg_wdata_in & bmask);
		next_power_state = (cfg_wdata_in[1:0] & bmask[1:0]) |
			(power_state & ~bmask[1:0]);
		// Unlock keeps its value so a ROM cannot open the ID fields
		rom_ext_a = (rom_data_in & `EXT_A_WMASK & ~`UNLOCK_MASK) |
			(vendor_config_ext_a & `UNLOCK_MASK); // RULE11
	end

	always @* begin
		case (cfg_addr_in)
		`OFF_EXT_A:  rdata = vendor_config_ext_a | `EXT_A_RO_ONE; // RULE16
		`OFF_EXT_B:  rdata = vendor_config_ext_b; // RULE16
		`OFF_PMCSR:  rdata = {{30{1'b0}}, power_state};
		`OFF_SUBSYS: rdata = subsys_id;
		default:     rdata = `RDATA_RESET;
		endcase
	end

	always @* begin
		ports = vendor_config_ext_a[`BIT_PORT_LO +: `PORTS_W];
		ports_legal = (ports <= `PORTS_MAX) && (ports >= `PORTS_MIN);
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			cfg_ack_out <= 1'b0;
		end else begin
			cfg_ack_out <= cfg_access;
		end
	end

	// Read data holds until the next read
	always @(posedge clk_in) begin
		if (rst_in) begin
			cfg_rdata_out <= `RDATA_RESET;
		end else if (cfg_rd_in) begin
			cfg_rdata_out <= rdata;
		end
	end

	// Once software touches config space the preload window is shut
	always @(posedge clk_in) begin
		if (rst_in) begin
			cfg_started <= 1'b0;
		end else if (cfg_access) begin
			cfg_started <= 1'b1;
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			vendor_config_ext_a <= `EXT_A_RESET; // RULE2 RULE7 RULE8 RULE9
		end else if (wr_ext_a) begin
			vendor_config_ext_a <= next_ext_a; // RULE12
		end else if (rom_take) begin
			vendor_config_ext_a <= rom_ext_a; // RULE11
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			vendor_config_ext_b <= `EXT_B_RESET; // RULE13 RULE14
		end else if (wr_ext_b) begin
			vendor_config_ext_b <= next_ext_b; // RULE16
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			power_state <= `PS_D0;
		end else if (wr_pmcsr) begin
			power_state <= next_power_state; // RULE15
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			subsys_id <= `SUBSYS_RESET;
		end else if (wr_subsys && vendor_config_ext_a[`BIT_UNLOCK]) begin
			subsys_id <= next_subsys; // RULE8
		end
	end

	// Illegal port counts fall back to none enabled rather than guessing
	always @(posedge clk_in) begin
		if (rst_in) begin
			port_enable_out <= `PORT_EN_RESET;
		end else if (ports_legal) begin
			port_enable_out <= `PORT_EN_ALL >> (`PORTS_MAX - ports); // RULE2
		end else begin
			port_enable_out <= `PORT_EN_NONE;
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			legacy_direct_out <= 1'b0;
		end else begin
			legacy_direct_out <= legacy_pin_in &
				~vendor_config_ext_a[`BIT_LEGC]; // RULE3 RULE5
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			legacy_window_out <= 1'b0;
		end else begin
			legacy_window_out <= legacy_pin_in &
				vendor_config_ext_a[`BIT_LEGC]; // RULE4 RULE5
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			port_power_control_cap_out <= `PPC_RESET;
		end else begin
			port_power_control_cap_out <=
				vendor_config_ext_a[`BIT_PPC]; // RULE9
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			clk_sel_48m_out <= 1'b0;
		end else begin
			clk_sel_48m_out <= vendor_config_ext_b[`BIT_CLK_SEL]; // RULE13
		end
	end

	// Clock stop is only reported; gating is left to the clock tree
	always @(posedge clk_in) begin
		if (rst_in) begin
			suspend_out <= 1'b0;
		end else begin
			suspend_out <= (power_state != `PS_D0); // RULE1
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			clock_stop_out <= 1'b0;
		end else begin
			clock_stop_out <= (power_state != `PS_D0); // RULE1
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			power_state_out <= `PS_D0;
		end else begin
			power_state_out <= power_state; // RULE15
		end
	end

endmodule // usb_host_vendor_config_regs
`default_nettype wire

/* File: cfg_regs_sva.sv */
// Purpose: Port checks for the vendor config registers
// Assumes: One-cycle ack, derived outputs settle two edges on
// Notes: Only design-driven signals are judged
`timescale 1ns/1ps
`default_nettype none
module cfg_regs_sva (
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        cfg_wr_in,
	input wire logic        cfg_rd_in,
	input wire logic [7:0]  cfg_addr_in,
	input wire logic        legacy_pin_in,
	input wire logic [31:0] cfg_rdata_out,
	input wire logic        cfg_ack_out,
	input wire logic [4:0]  port_enable_out,
	input wire logic        legacy_direct_out,
	input wire logic        legacy_window_out,
	input wire logic        suspend_out,
	input wire logic        clock_stop_out,
	input wire logic [1:0]  power_state_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	a_ack_after_req: assert property (
		(cfg_wr_in || cfg_rd_in) |=> cfg_ack_out)
		else $error("ack missing");
	a_ack_no_req: assert property (
		cfg_ack_out |-> $past(cfg_wr_in || cfg_rd_in))
		else $error("stray ack");
	a_pin_low_off: assert property (
		!legacy_pin_in [*2] |=> !legacy_direct_out && !legacy_window_out)
		else $error("legacy on");
	a_legacy_excl: assert property (
		!(legacy_direct_out && legacy_window_out))
		else $error("both legacy");
	a_suspend_state: assert property (
		$stable(power_state_out) |->
		suspend_out == (power_state_out != 2'h0))
		else $error("suspend");
	a_stop_tracks: assert property (
		clock_stop_out == suspend_out)
		else $error("clock stop");
	a_ports_legal: assert property (
		port_enable_out inside {5'h1f, 5'h0f, 5'h07, 5'h03, 5'h00})
		else $error("ports");
	a_fixed_one: assert property (
		$past(cfg_rd_in && cfg_addr_in == 8'he0) |-> cfg_rdata_out[23])
		else $error("bit 23");
	a_extb_rsvd: assert property (
		$past(cfg_rd_in && cfg_addr_in == 8'he4) |->
		cfg_rdata_out[31:7] == 25'h0 && !cfg_rdata_out[0])
		else $error("reserved");
endmodule // cfg_regs_sva
`default_nettype wire

/* File: usb_host_vendor_config_regs_tb.sv */
// Purpose: Directed bench for the vendor config registers
// Assumes: Full byte enables on every access
// Notes: Tuning fields always written back at their fixed values
`timescale 1ns/1ps
`default_nettype none
module usb_host_vendor_config_regs_tb;
	logic        clk_in        = 1'b0;
	logic        rst_in        = 1'b1;
	logic        cfg_wr_in     = 1'b0;
	logic        cfg_rd_in     = 1'b0;
	logic        rom_load_in   = 1'b0;
	logic        legacy_pin_in = 1'b0;
	logic [7:0]  cfg_addr_in   = 8'h00;
	logic [3:0]  cfg_be_in     = 4'hf;
	logic [31:0] cfg_wdata_in  = 32'h0000_0000;
	logic [31:0] rom_data_in   = 32'h0000_0000;
	wire  [31:0] cfg_rdata_out;
	wire  [4:0]  port_enable_out;
	wire  [1:0]  power_state_out;
	wire         cfg_ack_out;
	wire         legacy_direct_out;
	wire         legacy_window_out;
	wire         port_power_control_cap_out;
	wire         clk_sel_48m_out;
	wire         suspend_out;
	wire         clock_stop_out;
	int          err_total = 0;
	int          tests_run = 0;
	int          i;
	usb_host_vendor_config_regs dut (
		.clk_in                     (clk_in),
		.rst_in                     (rst_in),
		.cfg_wr_in                  (cfg_wr_in),
		.cfg_rd_in                  (cfg_rd_in),
		.cfg_addr_in                (cfg_addr_in),
		.cfg_be_in                  (cfg_be_in),
		.cfg_wdata_in               (cfg_wdata_in),
		.rom_load_in                (rom_load_in),
		.rom_data_in                (rom_data_in),
		.legacy_pin_in              (legacy_pin_in),
		.cfg_rdata_out              (cfg_rdata_out),
		.cfg_ack_out                (cfg_ack_out),
		.port_enable_out            (port_enable_out),
		.legacy_direct_out          (legacy_direct_out),
		.legacy_window_out          (legacy_window_out),
		.port_power_control_cap_out (port_power_control_cap_out),
		.clk_sel_48m_out            (clk_sel_48m_out),
		.suspend_out                (suspend_out),
		.clock_stop_out             (clock_stop_out),
		.power_state_out            (power_state_out)
	);
	always #4 clk_in = ~clk_in;
	task finish_test;
		$display("errors %0d checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task ck(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task rs;
		rst_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
	endtask
	// Waits two edges after the strobe so derived outputs have landed
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in) begin
			cfg_wr_in    <= 1'b1;
			cfg_addr_in  <= a;
			cfg_wdata_in <= d;
		end
		@(posedge clk_in) cfg_wr_in <= 1'b0;
		#1 ck(cfg_ack_out, 32'h1);
		repeat (2) @(posedge clk_in);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_in) begin
			cfg_rd_in   <= 1'b1;
			cfg_addr_in <= a;
		end
		@(posedge clk_in) cfg_rd_in <= 1'b0;
		#1 ck(cfg_ack_out, 32'h1);
		ck(cfg_rdata_out, e);
	endtask
	task rom_pulse(input logic [31:0] d);
		@(posedge clk_in) begin
			rom_load_in <= 1'b1;
			rom_data_in <= d;
		end
		@(posedge clk_in) rom_load_in <= 1'b0;
		repeat (2) @(posedge clk_in);
	endtask
	task reset_values;
		ck(port_enable_out, 32'h1f);
		ck(port_power_control_cap_out, 32'h1);
		ck({suspend_out, clock_stop_out, power_state_out}, 32'h0);
		rd(8'he0, 32'h6cb03305);
		rd(8'he4, 32'h0);
	endtask
	task port_count;
		for (i = 2; i < 6; i++) begin
			wr(8'he0, 32'h6c103300 | i);
			ck(port_enable_out, (32'h1 << i) - 1);
		end
		ck(port_power_control_cap_out, 32'h0);
	endtask
	task subsys_locked;
		wr(8'h2c, 32'hffffffff);
		rd(8'h2c, 32'h0);
	endtask
	task legacy_decode;
		wr(8'he0, 32'h6c30330d);
		ck({legacy_direct_out, legacy_window_out}, 32'h0);
		ck(port_power_control_cap_out, 32'h1);
		legacy_pin_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		ck({legacy_direct_out, legacy_window_out}, 32'h1);
		wr(8'he0, 32'h6c303385);
		ck({legacy_direct_out, legacy_window_out}, 32'h2);
	endtask
	task subsys_open;
		wr(8'h2c, 32'h12345678);
		rd(8'h2c, 32'h12345678);
	endtask
	task ext_b_fields;
		wr(8'he4, 32'hffffffa1);
		rd(8'he4, 32'h20);
		ck(clk_sel_48m_out, 32'h1);
	endtask
	task power_suspend;
		wr(8'h84, 32'h3);
		ck({suspend_out, clock_stop_out, power_state_out}, 32'hf);
	endtask
	task rom_preload;
		rs;
		ck({suspend_out, clock_stop_out, power_state_out}, 32'h0);
		rom_pulse(32'h6c303382);
		ck(port_enable_out, 32'h3);
		rd(8'he0, 32'h6cb03302);
		rom_pulse(32'h6c303305);
		ck(port_enable_out, 32'h3);
		wr(8'h2c, 32'h0000abcd);
		rd(8'h2c, 32'h0);
	endtask
	initial begin
		rs;
		reset_values;
		port_count;
		subsys_locked;
		legacy_decode;
		subsys_open;
		ext_b_fields;
		power_suspend;
		rom_preload;
		finish_test;
	end
	// About 80 cycles are needed; this leaves a wide margin
	initial begin
		#20000;
		err_total++;
		finish_test;
	end
endmodule // usb_host_vendor_config_regs_tb
bind usb_host_vendor_config_regs cfg_regs_sva chk (
	.clk_in            (clk_in),
	.rst_in            (rst_in),
	.cfg_wr_in         (cfg_wr_in),
	.cfg_rd_in         (cfg_rd_in),
	.cfg_addr_in       (cfg_addr_in),
	.legacy_pin_in     (legacy_pin_in),
	.cfg_rdata_out     (cfg_rdata_out),
	.cfg_ack_out       (cfg_ack_out),
	.port_enable_out   (port_enable_out),
	.legacy_direct_out (legacy_direct_out),
	.legacy_window_out (legacy_window_out),
	.suspend_out       (suspend_out),
	.clock_stop_out    (clock_stop_out),
	.power_state_out   (power_state_out)
);
`default_nettype wire
